// ===== logic/tldc_coeff_dec.sv
`timescale 1ns/1ps
module tldc_coeff_dec (
  input  wire logic [tldc_pkg::SEL_W-1:0]   sel_i,   // Filter selector
  output logic                              en_o,    // Filter active
  output logic      [tldc_pkg::SHIFT_W-1:0] shift_o, // Exponent n+1
  output logic      [tldc_pkg::COEF_W-1:0]  coeff_o  // Coefficient, Q0.16
);

  wire                              is_bypass;
  wire [tldc_pkg::SHIFT_W-1:0]      sel_wide;
  wire [tldc_pkg::COEF_W:0]         coeff_full;

  assign is_bypass  = (sel_i == tldc_pkg::SEL_BYPASS);
  assign sel_wide   = {1'b0, sel_i};
  assign en_o       = !is_bypass;
  assign shift_o    = is_bypass ? 5'h00 : sel_wide + 5'h01;
  assign coeff_full = tldc_pkg::COEF_ONE >> shift_o;
  assign coeff_o    = is_bypass ? 16'h0000
                                : coeff_full[tldc_pkg::COEF_W-1:0];

endmodule // tldc_coeff_dec

// ===== logic/tldc_pkg.sv
package tldc_pkg;

  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned SHIFT_W = 5;
  localparam int unsigned COEF_W  = 16;
  localparam int unsigned THR_W   = 24;

  // Word addresses on the register port
  localparam logic [ADDR_W-1:0] THR_HIGH_ADDR = 4'h7;
  localparam logic [ADDR_W-1:0] THR_LOW_ADDR  = 4'h8;

  // Field positions
  localparam int unsigned LOW_BYTE_MSB = 15;
  localparam int unsigned LOW_BYTE_LSB = 8;
  localparam int unsigned RESV_MSB     = 7;
  localparam int unsigned RESV_LSB     = 4;
  localparam int unsigned SEL_MSB      = 3;
  localparam int unsigned SEL_LSB      = 0;

  // Reset values
  localparam logic [DATA_W-1:0] THR_HIGH_RST = 16'h0000;
  localparam logic [7:0]        LOW_BYTE_RST = 8'h00;
  localparam logic [SEL_W-1:0]  SEL_RST      = 4'h0;
  localparam logic [3:0]        RESV_VAL     = 4'h0;

  // Selector value that bypasses the filter
  localparam logic [SEL_W-1:0]  SEL_BYPASS   = 4'h0;
  // Unity in Q0.16 before the coefficient shift
  localparam logic [COEF_W:0]   COEF_ONE     = 17'h10000;

  typedef struct packed {
    logic [THR_W-1:0]   threshold;   // {high word, low byte}
    logic               filter_en;
    logic [SHIFT_W-1:0] coeff_shift; // coefficient = 2^-coeff_shift when filter_en; shift and coefficient both 0 in bypass
    logic [COEF_W-1:0]  coeff_q16;   // coefficient in Q0.16
  } tldc_cfg_t;

endpackage

// ===== logic/tldc_reg.sv
`timescale 1ns/1ps
module tldc_reg #(
  parameter int unsigned ADDR_W = tldc_pkg::ADDR_W, // Address width
  parameter int unsigned DATA_W = tldc_pkg::DATA_W  // Data width
) (
  input  wire logic              ref_clk_i, // 250 MHz clock
  input  wire logic              rst_i,     // Async reset, active high
  input  wire logic [ADDR_W-1:0] addr_i,    // Register word address
  input  wire logic [DATA_W-1:0] wdata_i,   // Write data
  input  wire logic              wr_i,      // Write strobe
  input  wire logic              rd_i,      // Read strobe
  output logic      [DATA_W-1:0] rdata_o,   // Read data, cycle after rd_i
  output tldc_pkg::tldc_cfg_t    cfg_o      // Settings to datapath
);

  // The map needs four address bits; only 16-bit words are decoded
  if (ADDR_W < 4 || DATA_W != 16) begin : g_bad_width
    $error("tldc_reg: ADDR_W must be >= 4 and DATA_W must be 16");
  end

  logic [15:0]                 detect_threshold_high_word;
  logic [7:0]                  detect_threshold_low_byte;
  logic [tldc_pkg::SEL_W-1:0]  offset_removal_coeff_sel;
  logic [DATA_W-1:0]           rdata;
  tldc_pkg::tldc_cfg_t         cfg;

  wire                         hit_high;
  wire                         hit_low;
  wire                         wr_high;
  wire                         wr_low;
  wire [DATA_W-1:0]            low_reg_view;
  wire [DATA_W-1:0]            next_rdata;
  wire                         dec_en;
  wire [tldc_pkg::SHIFT_W-1:0] dec_shift;
  wire [tldc_pkg::COEF_W-1:0]  dec_coeff;
  tldc_pkg::tldc_cfg_t         next_cfg;

  // Address decode
  assign hit_high = (addr_i == ADDR_W'(tldc_pkg::THR_HIGH_ADDR));
  assign hit_low  = (addr_i == ADDR_W'(tldc_pkg::THR_LOW_ADDR));
  assign wr_high  = wr_i && hit_high;
  assign wr_low   = wr_i && hit_low;

  // Reserved nibble is a constant, never stored
  assign low_reg_view = {detect_threshold_low_byte,
                         tldc_pkg::RESV_VAL,
                         offset_removal_coeff_sel};

  // Unmapped or idle reads return zero
  assign next_rdata = !rd_i    ? '0 :
                      hit_high ? detect_threshold_high_word :
                      hit_low  ? low_reg_view : '0;

  tldc_coeff_dec u_dec (
    .sel_i   (offset_removal_coeff_sel),
    .en_o    (dec_en),
    .shift_o (dec_shift),
    .coeff_o (dec_coeff)
  );

  assign next_cfg.threshold   = {detect_threshold_high_word,
                                 detect_threshold_low_byte};
  assign next_cfg.filter_en   = dec_en;
  assign next_cfg.coeff_shift = dec_shift;
  assign next_cfg.coeff_q16   = dec_coeff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      detect_threshold_high_word <= tldc_pkg::THR_HIGH_RST;
    end else if (wr_high) begin
      detect_threshold_high_word <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      detect_threshold_low_byte <= tldc_pkg::LOW_BYTE_RST;
      offset_removal_coeff_sel  <= tldc_pkg::SEL_RST;
    end else if (wr_low) begin
      detect_threshold_low_byte <=
        wdata_i[tldc_pkg::LOW_BYTE_MSB:tldc_pkg::LOW_BYTE_LSB];
      offset_removal_coeff_sel  <=
        wdata_i[tldc_pkg::SEL_MSB:tldc_pkg::SEL_LSB];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata <= '0;
      cfg   <= '0;
    end else begin
      rdata <= next_rdata;
      cfg   <= next_cfg;
    end
  end

  assign rdata_o = rdata;
  assign cfg_o   = cfg;

  // Checks

  a_reset_clears: assert property (
    @(posedge ref_clk_i) $fell(rst_i) |->
      (low_reg_view == 16'h0000) && (cfg.filter_en == 1'b0))
    else $error("low register not zero after reset");

  a_low_byte_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_low ##1 (rd_i && hit_low && !wr_i) |=>
      rdata_o[15:8] == $past(wdata_i[15:8], 2))
    else $error("threshold low byte readback wrong");

  a_sel_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_low |=> offset_removal_coeff_sel == $past(wdata_i[3:0]))
    else $error("selector not stored");

  a_bypass_zero: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (offset_removal_coeff_sel == 4'h0) |=>
      !cfg_o.filter_en && (cfg_o.coeff_q16 == 16'h0000))
    else $error("filter not bypassed at selector zero");

  a_coeff_value: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (offset_removal_coeff_sel != 4'h0) |=>
      cfg_o.filter_en &&
      (cfg_o.coeff_shift == 5'({1'b0, $past(offset_removal_coeff_sel)}
                              + 5'h01)) &&
      (cfg_o.coeff_q16 == 16'(17'h10000 >> cfg_o.coeff_shift)))
    else $error("coefficient does not match selector");

  a_high_word: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_high |=> ##1 cfg_o.threshold[23:8] == $past(wdata_i, 2))
    else $error("threshold high word not forwarded");

  a_resv_zero: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && hit_low) |=> rdata_o[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  a_rdata_idle: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero outside read answer");

  // Reset and address map

  a_reset_outputs: assert property (
    @(posedge ref_clk_i) $fell(rst_i) |->
      (rdata_o == 16'h0000) && (cfg_o == '0) &&
      (detect_threshold_high_word == 16'h0000))
    else $error("outputs not cleared after reset");

  a_unmapped_read: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && !hit_high && !hit_low) |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");

  a_unmapped_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && !hit_high && !hit_low) |=>
      $stable(detect_threshold_high_word) &&
      $stable(detect_threshold_low_byte) &&
      $stable(offset_removal_coeff_sel))
    else $error("unmapped write changed a register");

  // Register storage

  a_low_readback: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && hit_low) |=>
      rdata_o == {$past(detect_threshold_low_byte), 4'h0,
                  $past(offset_removal_coeff_sel)})
    else $error("low register readback wrong");

  a_low_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !wr_low |=> $stable(detect_threshold_low_byte) &&
                $stable(offset_removal_coeff_sel))
    else $error("low register changed without a write");

  a_high_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_high |=> detect_threshold_high_word == $past(wdata_i))
    else $error("threshold high word not stored");

  a_high_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !wr_high |=> $stable(detect_threshold_high_word))
    else $error("high word changed without a write");

  a_high_readback: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_i && hit_high) |=> rdata_o == $past(detect_threshold_high_word))
    else $error("threshold high word readback wrong");

  // Settings towards the datapath

  a_low_fwd: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wr_low |=> ##1 cfg_o.threshold[7:0] == $past(wdata_i[15:8], 2))
    else $error("threshold low byte not forwarded");

  a_bypass_fields: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !cfg_o.filter_en |->
      (cfg_o.coeff_shift == 5'h00) && (cfg_o.coeff_q16 == 16'h0000))
    else $error("bypass left coefficient fields nonzero");

  a_coeff_range: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    cfg_o.filter_en |->
      (cfg_o.coeff_shift >= 5'h02) && (cfg_o.coeff_shift <= 5'h10) &&
      ((17'(cfg_o.coeff_q16) << cfg_o.coeff_shift) == 17'h10000))
    else $error("coefficient outside quarter to 1/65536");

  a_coeff_first: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (offset_removal_coeff_sel == 4'h1) |=> cfg_o.coeff_q16 == 16'h4000)
    else $error("selector one is not a quarter");

  a_coeff_last: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (offset_removal_coeff_sel == 4'hF) |=> cfg_o.coeff_q16 == 16'h0001)
    else $error("selector fifteen is not 1/65536");

endmodule // tldc_reg

// ===== verification/tldc_tb.sv
`timescale 1ns/1ps
module testbench;
  logic                        ref_clk_i = 1'b0;
  logic                        rst_i     = 1'b1;
  logic [tldc_pkg::ADDR_W-1:0] addr_i    = '0;
  logic [tldc_pkg::DATA_W-1:0] wdata_i   = '0;
  logic                        wr_i      = 1'b0;
  logic                        rd_i      = 1'b0;
  logic [tldc_pkg::DATA_W-1:0] rdata_o;
  tldc_pkg::tldc_cfg_t         cfg_o;
  logic                        rd_q      = 1'b0;
  logic [15:0]                 exp_q[$];
  logic [15:0]                 d;
  logic [15:0]                 hi;
  int                          n_errors  = 0;
  int                          compares  = 0;
  int                          seed      = 32'h9e426855;
  logic                        cfg_due   = 1'b0;
  tldc_pkg::tldc_cfg_t         cfg_q[$];
  tldc_pkg::tldc_cfg_t         e;
  tldc_pkg::tldc_cfg_t         c;
  logic [31:0]                 r;

  always #2 ref_clk_i = ~ref_clk_i;

  tldc_reg DUT (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .addr_i    (addr_i),
    .wdata_i   (wdata_i),
    .wr_i      (wr_i),
    .rd_i      (rd_i),
    .rdata_o   (rdata_o),
    .cfg_o     (cfg_o)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Each bus task sets every strobe once, so calls may follow back to back
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    rd_i    <= 1'b0;
    cfg_due <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // Expected read data is queued for the watcher below
  task automatic rd(input logic [3:0] a, input logic [15:0] v);
    addr_i  <= a;
    wr_i    <= 1'b0;
    rd_i    <= 1'b1;
    cfg_due <= 1'b0;
    exp_q.push_back(v);
    @(posedge ref_clk_i);
  endtask

  // One idle cycle; with a note, cfg_o is compared in that cycle
  task automatic idle(input logic note);
    wr_i    <= 1'b0;
    rd_i    <= 1'b0;
    cfg_due <= note;
    if (note) cfg_q.push_back(e);
    @(posedge ref_clk_i);
  endtask

  always @(posedge ref_clk_i) rd_q <= rd_i;

  // Read data stands only in the cycle after the strobe, zero elsewhere
  always @(negedge ref_clk_i) begin
    if (rd_q) begin
      r = 32'h0001_0000; // A missing note can never match
      if (exp_q.size() > 0) r = {16'h0000, exp_q.pop_front()};
      check(rdata_o, r);
    end else begin
      check(rdata_o, 32'h0000_0000);
    end
    if (cfg_due) begin
      c = ~cfg_o; // A missing note can never match
      if (cfg_q.size() > 0) c = cfg_q.pop_front();
      check(cfg_o.threshold[23:8], c.threshold[23:8]);
      check(cfg_o.threshold[7:0], c.threshold[7:0]);
      check(cfg_o.filter_en, c.filter_en);
      check(cfg_o.coeff_shift, c.coeff_shift);
      check(cfg_o.coeff_q16, c.coeff_q16);
    end
  end

  initial begin
    hi = 16'h0000;
    e  = '0;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    idle(1'b1);
    rd(4'h8, 16'h0000);
    rd(4'h7, 16'h0000);
    for (int n = 0; n < 16; n++) begin
      d = 16'($random(seed));
      d[3:0] = n[3:0];
      d[7:4] = 4'h0;
      e.threshold   = {hi, d[15:8]};
      e.filter_en   = (n != 0);
      e.coeff_shift = n ? 5'(n + 1) : 5'h00;
      e.coeff_q16   = n ? 16'(32'h0001_0000 >> (n + 1)) : 16'h0000;
      wr(4'h8, d);
      rd(4'h8, d & 16'hFF0F);
      idle(1'b1);
    end
    hi = 16'($random(seed));
    e.threshold = {hi, d[15:8]};
    wr(4'h7, hi);
    wr(4'h9, 16'hFFFF);
    rd(4'h9, 16'h0000);
    rd(4'h7, hi);
    rd(4'h8, d & 16'hFF0F);
    idle(1'b1);
    rst_i <= 1'b1;
    e = '0;
    idle(1'b1);
    rst_i <= 1'b0;
    idle(1'b1);
    rd(4'h8, 16'h0000);
    rd(4'h7, 16'h0000);
    for (int i = 0; i < 4 && exp_q.size() + cfg_q.size() > 0; i++) begin
      idle(1'b0);
    end
    check(exp_q.size() + cfg_q.size(), 0);
    finish_test();
  end
endmodule // testbench
